// *** rtl/thermo_pkg.sv ***
package thermo_pkg;

    // Command codes received after the write address
    localparam logic [7:0] CMD_START_CONV = 8'h51;
    localparam logic [7:0] CMD_STOP_CONV = 8'h22;
    localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
    localparam logic [7:0] HIGH_LIMIT_ACCESS_CMD = 8'hA1;
    localparam logic [7:0] LOW_LIMIT_ACCESS_CMD = 8'hA2;
    localparam logic [7:0] CMD_ACCESS_CFG = 8'hAC;

    // Configuration byte field positions
    localparam int CFG_DONE_POS = 7;
    localparam int CFG_THF_POS = 6;
    localparam int CFG_TLF_POS = 5;
    localparam int CFG_NVB_POS = 4;
    localparam int CFG_RES_HI_POS = 3;
    localparam int CFG_RES_LO_POS = 2;
    localparam int CFG_POL_POS = 1;
    localparam int CFG_ONESHOT_POS = 0;

    // Reset values: 12-bit, continuous, active-low output
    localparam logic [7:0] CFG_RESET = 8'h0C;
    localparam logic [15:0] HIGH_THRESHOLD_RESET = 16'h5000;
    localparam logic [15:0] LOW_THRESHOLD_RESET = 16'h4B00;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    // Low nibble of a 12-bit threshold is not stored
    localparam logic [15:0] THRESHOLD_MASK = 16'hFFF0;

    // Bits per byte on the serial bus
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Bus protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } bus_state_e;

    // Configuration and status byte as fields
    typedef struct packed {
        logic done;
        logic thf;
        logic tlf;
        logic nvb;
        logic [1:0] res;
        logic pol;
        logic one_shot;
    } cfg_s;

endpackage

// *** rtl/thermostat_compare.sv ***
`timescale 1ns/1ps
// Hysteresis comparator and sticky high/low flags
module thermostat_compare (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic update_i,
    input wire logic [15:0] temp_i,
    input wire logic [15:0] high_threshold_i,
    input wire logic [15:0] low_threshold_i,
    input wire logic pol_i,
    input wire logic flag_clear_i,
    output logic thf_o,
    output logic tlf_o,
    output logic thermostat_output_o
);

    logic active_reg; // Alarm state before polarity
    logic thf_reg; // Sticky over-limit flag
    logic tlf_reg; // Sticky under-limit flag
    logic out_reg; // Registered pin level
    logic above_high; // Temperature above high limit
    logic at_or_below_low; // Temperature at or under low limit
    logic active_next;
    logic thf_next;
    logic tlf_next;

    // Two's complement compare on signed readings
    assign above_high = $signed(temp_i) > $signed(high_threshold_i);
    assign at_or_below_low = $signed(temp_i) <= $signed(low_threshold_i);

    // Set above high, release only at or under low
    assign active_next = update_i ? (above_high | (active_reg & ~at_or_below_low)) : active_reg;
    // A fresh event beats a clear in the same cycle
    assign thf_next = (update_i & above_high) | (thf_reg & ~flag_clear_i);
    assign tlf_next = (update_i & at_or_below_low) | (tlf_reg & ~flag_clear_i);

    // State and flags; pin idles inactive for active-low polarity
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            active_reg <= 1'b0;
            thf_reg <= 1'b0;
            tlf_reg <= 1'b0;
            out_reg <= 1'b1;
        end else begin
            active_reg <= active_next;
            thf_reg <= thf_next;
            tlf_reg <= tlf_next;
            out_reg <= pol_i ? active_next : ~active_next;
        end
    end

    assign thf_o = thf_reg;
    assign tlf_o = tlf_reg;
    assign thermostat_output_o = out_reg;

endmodule // thermostat_compare

// *** rtl/thermostat_command_port.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Acknowledge own address, commands, written bytes.
// - Code 51h starts conversion, no data.
// - Code AAh selects temperature for reading.
// - Temperature read sends high byte first.
// - Second read byte is temperature low byte.
// - Code ACh writes one configuration byte.
// - Configuration write clears high/low flags.
// - Value 08h: 11-bit, continuous, active low.
// - Code A1h writes high limit, two bytes.
// - Code A2h writes low limit, two bytes.
// - First limit byte is whole degrees.
// - Second limit byte is the fraction.
// - Transactions chain through repeated START conditions.
// - Match type code and select pins.
// - Code 22h drops the run request at once.
// - One-shot converts once; continuous repeats.
module thermostat_command_port #(
    parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary value, not a real part code
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_bit0_i,
    input wire logic addr_select_bit1_i,
    input wire logic addr_select_bit2_i,
    input wire logic conv_done_i,
    input wire logic [15:0] temp_result_i,
    output logic conv_run_o,
    output logic [1:0] resolution_o,
    output logic thermostat_output_o
);

    // Refuse a type code wider than the address field
    if ($bits(DEV_TYPE) != 4) begin : g_type_check
        $error("DEV_TYPE must be four bits");
    end

    thermo_pkg::bus_state_e state_reg, state_next; // Protocol state
    logic scl_q; // Previous clock sample
    logic sda_q; // Previous data sample
    logic [3:0] bit_cnt_reg, bit_cnt_next; // Bits of current byte
    logic [7:0] rx_sh_reg, rx_sh_next; // Received byte
    logic [7:0] tx_sh_reg, tx_sh_next; // Byte being sent
    logic oe_reg, oe_next; // Pulling data low
    logic [7:0] cmd_reg, cmd_next; // Last command code
    logic rw_reg, rw_next; // Direction of current transaction
    logic second_reg, second_next; // Next byte is the low byte
    logic [15:0] temp_reg; // Last stored conversion
    logic [15:0] high_threshold_reg; // Upper alarm limit
    logic [15:0] low_threshold_reg; // Lower alarm limit
    thermo_pkg::cfg_s cfg_reg; // Stored mode fields
    logic run_reg; // Conversions requested
    logic done_reg; // A conversion has finished
    logic thf; // Flags from comparator
    logic tlf;

    // Bus events decoded from two successive samples
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic byte_done; // Eighth bit latched
    logic addr_match;
    logic wr_strobe; // One written data byte taken
    logic cmd_strobe; // One command byte taken
    logic start_cmd;
    logic stop_cmd;
    logic cfg_write;
    logic [7:0] rd_byte; // Byte selected for the next read
    thermo_pkg::cfg_s cfg_view; // Configuration as read back

    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    // Data edges while the clock stays high frame a transaction
    assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;
    assign byte_done = scl_fall & (bit_cnt_reg == thermo_pkg::BITS_PER_BYTE);

    // Type code, then select pins, then the direction bit
    assign addr_match = (rx_sh_reg[7:4] == DEV_TYPE) &&
        (rx_sh_reg[3:1] == {addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i});

    // Read-back view of the configuration byte
    always_comb begin
        cfg_view = cfg_reg;
        cfg_view.done = done_reg;
        cfg_view.thf = thf;
        cfg_view.tlf = tlf;
        cfg_view.nvb = 1'b0;
    end

    // Read byte select; high byte first, low byte second
    function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic low);
        pick_byte = low ? word[7:0] : word[15:8];
    endfunction

    assign rd_byte = (cmd_reg == thermo_pkg::CMD_READ_TEMP) ? pick_byte(temp_reg, second_reg) :
        (cmd_reg == thermo_pkg::HIGH_LIMIT_ACCESS_CMD) ? pick_byte(high_threshold_reg, second_reg) :
        (cmd_reg == thermo_pkg::LOW_LIMIT_ACCESS_CMD) ? pick_byte(low_threshold_reg, second_reg) :
        (cmd_reg == thermo_pkg::CMD_ACCESS_CFG) ? cfg_view : 8'hFF;

    // Command and write strobes at the end of a received byte
    assign cmd_strobe = (state_reg == thermo_pkg::ST_CMD) & byte_done;
    assign wr_strobe = (state_reg == thermo_pkg::ST_WDATA) & byte_done;
    assign start_cmd = cmd_strobe & (rx_sh_reg == thermo_pkg::CMD_START_CONV);
    assign stop_cmd = cmd_strobe & (rx_sh_reg == thermo_pkg::CMD_STOP_CONV);
    assign cfg_write = wr_strobe & (cmd_reg == thermo_pkg::CMD_ACCESS_CFG) & ~second_reg;

    // Protocol sequencing; START and STOP override any state
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        rx_sh_next = rx_sh_reg;
        tx_sh_next = tx_sh_reg;
        oe_next = oe_reg;
        cmd_next = cmd_reg;
        rw_next = rw_reg;
        second_next = second_reg;
        if (start_cond) begin
            // Repeated START keeps the command for a read
            state_next = thermo_pkg::ST_ADDR;
            bit_cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop_cond) begin
            // Bus released after the final STOP
            state_next = thermo_pkg::ST_IDLE;
            oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                thermo_pkg::ST_IDLE, thermo_pkg::ST_IGNORE: begin
                    oe_next = 1'b0;
                end
                thermo_pkg::ST_ADDR, thermo_pkg::ST_CMD, thermo_pkg::ST_WDATA: begin
                    // Shift in on rising clock, decide on the eighth fall
                    if (scl_rise && bit_cnt_reg != thermo_pkg::BITS_PER_BYTE) begin
                        rx_sh_next = {rx_sh_reg[6:0], sda_i};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    if (byte_done) begin
                        bit_cnt_next = 4'h0;
                        if (state_reg == thermo_pkg::ST_ADDR) begin
                            rw_next = rx_sh_reg[0];
                            // Only a matching address is acknowledged
                            oe_next = addr_match;
                            state_next = addr_match ? thermo_pkg::ST_ADDR_ACK
                                                    : thermo_pkg::ST_IGNORE;
                        end else if (state_reg == thermo_pkg::ST_CMD) begin
                            // Every command byte is acknowledged
                            cmd_next = rx_sh_reg;
                            second_next = 1'b0;
                            oe_next = 1'b1;
                            state_next = thermo_pkg::ST_CMD_ACK;
                        end else begin
                            // Written data byte acknowledged
                            oe_next = 1'b1;
                            state_next = thermo_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                thermo_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            // Turnaround: first read byte from the stored command
                            second_next = 1'b0;
                            tx_sh_next = rd_byte;
                            oe_next = ~rd_byte[7];
                            state_next = thermo_pkg::ST_RDATA;
                        end else begin
                            oe_next = 1'b0;
                            state_next = thermo_pkg::ST_CMD;
                        end
                    end
                end
                thermo_pkg::ST_CMD_ACK, thermo_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = thermo_pkg::ST_WDATA;
                        if (state_reg == thermo_pkg::ST_WDATA_ACK) begin
                            second_next = 1'b1;
                        end
                    end
                end
                thermo_pkg::ST_RDATA: begin
                    // Most significant bit first, changed while clock is low
                    if (scl_fall) begin
                        if (bit_cnt_reg == thermo_pkg::BITS_PER_BYTE - 4'h1) begin
                            bit_cnt_next = 4'h0;
                            oe_next = 1'b0;
                            state_next = thermo_pkg::ST_RACK;
                        end else begin
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                            tx_sh_next = {tx_sh_reg[6:0], 1'b0};
                            oe_next = ~tx_sh_reg[6];
                        end
                    end
                end
                thermo_pkg::ST_RACK: begin
                    // Master ACK asks for the next byte, NACK ends it
                    if (scl_rise) begin
                        state_next = sda_i ? thermo_pkg::ST_IGNORE : thermo_pkg::ST_RACK;
                        second_next = ~second_reg;
                    end
                    if (scl_fall) begin
                        tx_sh_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        state_next = thermo_pkg::ST_RDATA;
                    end
                end
                default: begin
                    state_next = thermo_pkg::ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    // Bus sampling and protocol registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state_reg <= thermo_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_sh_reg <= 8'h00;
            tx_sh_reg <= 8'h00;
            oe_reg <= 1'b0;
            cmd_reg <= 8'h00;
            rw_reg <= 1'b0;
            second_reg <= 1'b0;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_sh_reg <= rx_sh_next;
            tx_sh_reg <= tx_sh_next;
            oe_reg <= oe_next;
            cmd_reg <= cmd_next;
            rw_reg <= rw_next;
            second_reg <= second_next;
        end
    end

    // Configuration: 08h gives 11-bit, continuous, active low
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_reg <= thermo_pkg::CFG_RESET;
        end else if (cfg_write) begin
            cfg_reg.res <= rx_sh_reg[thermo_pkg::CFG_RES_HI_POS:thermo_pkg::CFG_RES_LO_POS];
            cfg_reg.pol <= rx_sh_reg[thermo_pkg::CFG_POL_POS];
            cfg_reg.one_shot <= rx_sh_reg[thermo_pkg::CFG_ONESHOT_POS];
        end
    end

    // Limits: first byte whole degrees, second the fraction
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            high_threshold_reg <= thermo_pkg::HIGH_THRESHOLD_RESET;
            low_threshold_reg <= thermo_pkg::LOW_THRESHOLD_RESET;
        end else if (wr_strobe) begin
            if (cmd_reg == thermo_pkg::HIGH_LIMIT_ACCESS_CMD) begin
                high_threshold_reg <= (second_reg ? {high_threshold_reg[15:8], rx_sh_reg}
                    : {rx_sh_reg, high_threshold_reg[7:0]}) & thermo_pkg::THRESHOLD_MASK;
            end
            if (cmd_reg == thermo_pkg::LOW_LIMIT_ACCESS_CMD) begin
                low_threshold_reg <= (second_reg ? {low_threshold_reg[15:8], rx_sh_reg}
                    : {rx_sh_reg, low_threshold_reg[7:0]}) & thermo_pkg::THRESHOLD_MASK;
            end
        end
    end

    // Conversion control; stop drops the run request at once
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_reg <= 1'b0;
            done_reg <= 1'b0;
            temp_reg <= thermo_pkg::TEMP_RESET;
        end else begin
            if (conv_done_i) begin
                temp_reg <= temp_result_i;
                done_reg <= 1'b1;
                if (cfg_reg.one_shot) begin
                    run_reg <= 1'b0;
                end
            end
            if (stop_cmd) begin
                run_reg <= 1'b0;
            end
            if (start_cmd) begin
                run_reg <= 1'b1;
                done_reg <= 1'b0;
            end
        end
    end

    // Alarm output and flags; a config write clears the flags
    thermostat_compare u_compare (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .update_i(conv_done_i),
        .temp_i(temp_result_i),
        .high_threshold_i(high_threshold_reg),
        .low_threshold_i(low_threshold_reg),
        .pol_i(cfg_reg.pol),
        .flag_clear_i(cfg_write),
        .thf_o(thf),
        .tlf_o(tlf),
        .thermostat_output_o(thermostat_output_o)
    );

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;
    assign conv_run_o = run_reg;
    assign resolution_o = cfg_reg.res;

endmodule // thermostat_command_port

// *** bench/thermostat_command_port_properties.sv ***
`timescale 1ns/1ps
// Timing relations seen at the port pins
module thermostat_command_port_checker (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic conv_done_i,
    input wire logic conv_run_o,
    input wire logic [1:0] resolution_o,
    input wire logic thermostat_output_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Bus clock held high on two samples
    sequence s_scl_high2;
        scl_i && $past(scl_i);
    endsequence
    // Data rising while the bus clock is high
    sequence s_stop;
        s_scl_high2 ##0 $rose(sda_i);
    endsequence
    // Low phase shortly after a bus clock fall; allows for the input sample stage
    sequence s_recent_fall;
        !scl_i && ($past(scl_i) || $past(scl_i, 2) || $past(scl_i, 3));
    endsequence
    a_drain_only: assert property (sda_o == 1'b0)
        else $error("data output not held low");
    a_oe_after_fall: assert property ($changed(sda_oe_o) |-> s_recent_fall)
        else $error("data drive changed away from a clock fall");
    a_oe_hold_high: assert property (s_scl_high2 |-> $stable(sda_oe_o))
        else $error("data drive changed while clock high");
    a_stop_release: assert property (s_stop |=> !sda_oe_o [*4])
        else $error("data driven after stop");
    a_res_on_fall: assert property ($changed(resolution_o) |-> s_recent_fall)
        else $error("resolution changed outside a byte end");
    a_run_start: assert property ($rose(conv_run_o) |-> s_recent_fall)
        else $error("conversion started without a command");
    a_run_stop: assert property ($fell(conv_run_o) |->
        s_recent_fall or ($past(conv_done_i) || $past(conv_done_i, 2)))
        else $error("conversion stopped without cause");
    a_alarm_update: assert property ($changed(thermostat_output_o) |-> s_recent_fall or
        ($past(conv_done_i) || $past(conv_done_i, 2) || $past(conv_done_i, 3)))
        else $error("alarm pin changed without a result");
endmodule // thermostat_command_port_checker

bind thermostat_command_port thermostat_command_port_checker u_chk (.*);

// *** bench/two_wire_master.sv ***
`timescale 1ns/1ps
// Behavioural bus master; slow clock, open-drain data
module two_wire_master #(
    parameter int HALF = 5 // Ref cycles per bus clock phase
) (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Bus idles released, clock high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Wait n ref edges
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        tick(1);
        sda_low_o <= 1'b0;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        sda_low_o <= 1'b1;
        tick(HALF);
        scl_o <= 1'b0;
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        tick(1);
        sda_low_o <= 1'b1;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        sda_low_o <= 1'b0;
        tick(HALF);
    endtask
    // Data moves one edge after the fall, so hold is never broken
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_low_o <= !b;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    // Byte out first bit highest, then the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Byte in; refused when it is the last one wanted
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule // two_wire_master

// *** bench/thermostat_command_port_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the serial command port
module thermostat_command_port_tb;
    localparam logic [3:0] DEV = 4'h6; // Arbitrary type code
    localparam logic [2:0] SEL = 3'h5; // Select pin strapping
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic conv_done_i = 1'b0;
    logic [15:0] temp_result_i = 16'h0000;
    logic scl, m_low, sda_o, sda_oe_o, conv_run_o, alarm;
    logic [1:0] resolution_o;
    wire logic sda_line;
    int num_errors = 0;
    int cmp_count = 0;
    // Wired-AND with pull-up
    assign sda_line = !(m_low || sda_oe_o);
    always #50 ref_clk_i = !ref_clk_i;
    thermostat_command_port #(.DEV_TYPE(DEV)) u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .addr_select_bit0_i(SEL[0]), .addr_select_bit1_i(SEL[1]), .addr_select_bit2_i(SEL[2]),
        .conv_done_i(conv_done_i), .temp_result_i(temp_result_i), .conv_run_o(conv_run_o),
        .resolution_o(resolution_o), .thermostat_output_o(alarm));
    two_wire_master u_m (.ref_clk_i(ref_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));
    // Compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Start, write address, command, n data bytes; no stop so calls chain
    task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
        logic ack;
        u_m.start();
        u_m.send_byte({DEV, SEL, 1'b0}, ack);
        check("addr ack", 1'b1, ack);
        u_m.send_byte(cmd, ack);
        check("cmd ack", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            u_m.send_byte(i == 0 ? d[15:8] : d[7:0], ack);
            check("data ack", 1'b1, ack);
        end
    endtask
    // Repeated start, read address, n bytes with the last refused, stop
    task automatic rd(input int n, output logic [15:0] d);
        logic ack;
        logic [7:0] b;
        d = 16'h0000;
        u_m.start();
        u_m.send_byte({DEV, SEL, 1'b1}, ack);
        check("read addr ack", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            u_m.recv_byte(i == n - 1, b);
            d = {d[7:0], b};
        end
        u_m.stop();
    endtask
    // One converter result pulse
    task automatic conv(input logic [15:0] t);
        @(posedge ref_clk_i);
        temp_result_i <= t;
        conv_done_i <= 1'b1;
        @(posedge ref_clk_i);
        conv_done_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // Reset levels, then a start command
    task automatic t_reset_start();
        check("res reset", 2'h3, resolution_o);
        check("alarm reset", 1'b1, alarm);
        check("run reset", 1'b0, conv_run_o);
        wr(thermo_pkg::CMD_START_CONV, 0, 16'h0000);
        u_m.stop();
        check("run", 1'b1, conv_run_o);
        $display("t_reset_start done");
    endtask
    // Temperature read, two bytes then one byte
    task automatic t_read_temp();
        logic [15:0] d;
        conv(16'h1A50);
        wr(thermo_pkg::CMD_READ_TEMP, 0, 16'h0000);
        rd(2, d);
        check("temp", 16'h1A50, d);
        wr(thermo_pkg::CMD_READ_TEMP, 0, 16'h0000);
        rd(1, d);
        check("temp msb", 16'h001A, d);
        check("alarm low temp", 1'b1, alarm);
        $display("t_read_temp done");
    endtask
    // Wrong select bits, wrong type code
    task automatic t_bad_addr();
        logic ack;
        u_m.start();
        u_m.send_byte({DEV, SEL ^ 3'h1, 1'b0}, ack);
        check("select nack", 1'b0, ack);
        u_m.start();
        u_m.send_byte({DEV ^ 4'h8, SEL, 1'b0}, ack);
        check("type nack", 1'b0, ack);
        u_m.stop();
        $display("t_bad_addr done");
    endtask
    // Chained configuration and limit writes, readback, hysteresis
    task automatic t_cfg_limits();
        logic [15:0] d;
        conv(16'h5500);
        check("alarm above", 1'b0, alarm);
        wr(thermo_pkg::CMD_ACCESS_CFG, 1, 16'h0800);
        wr(thermo_pkg::HIGH_LIMIT_ACCESS_CMD, 2, 16'h3200);
        wr(thermo_pkg::LOW_LIMIT_ACCESS_CMD, 2, 16'h2D00);
        wr(thermo_pkg::CMD_START_CONV, 0, 16'h0000);
        u_m.stop();
        check("res", 2'h2, resolution_o);
        wr(thermo_pkg::CMD_ACCESS_CFG, 0, 16'h0000);
        rd(1, d);
        check("cfg", 16'h0008, d);
        wr(thermo_pkg::HIGH_LIMIT_ACCESS_CMD, 0, 16'h0000);
        rd(2, d);
        check("high", 16'h3200, d);
        wr(thermo_pkg::LOW_LIMIT_ACCESS_CMD, 0, 16'h0000);
        rd(2, d);
        check("low", 16'h2D00, d);
        conv(16'h3000);
        check("alarm between", 1'b0, alarm);
        conv(16'h2D00);
        check("alarm at low", 1'b1, alarm);
        conv(16'h3210);
        check("alarm over high", 1'b0, alarm);
        // Continuous mode keeps converting after each result
        check("run continuous", 1'b1, conv_run_o);
        $display("t_cfg_limits done");
    endtask
    // Stop command, then a one-shot run
    task automatic t_stop_oneshot();
        wr(thermo_pkg::CMD_STOP_CONV, 0, 16'h0000);
        u_m.stop();
        check("run stopped", 1'b0, conv_run_o);
        wr(thermo_pkg::CMD_ACCESS_CFG, 1, 16'h0900);
        wr(thermo_pkg::CMD_START_CONV, 0, 16'h0000);
        u_m.stop();
        check("one-shot run", 1'b1, conv_run_o);
        conv(16'h2000);
        check("one-shot idle", 1'b0, conv_run_o);
        // Alarm inactive; active-high polarity drives the pin low
        wr(thermo_pkg::CMD_ACCESS_CFG, 1, 16'h0A00);
        u_m.stop();
        check("alarm active high", 1'b0, alarm);
        $display("t_stop_oneshot done");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        t_reset_start();
        t_read_temp();
        t_bad_addr();
        t_cfg_limits();
        t_stop_oneshot();
        close_out();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        num_errors++;
        $display("Error watchdog expected end seen timeout");
        close_out();
    end
endmodule // thermostat_command_port_tb
